// *** logic/phy_pages_pkg.sv ***
// shared constants, carriers and state layout for the phy id and control pages
package phy_pages_pkg;

    localparam int          CLK_PERIOD_NS = 50;
    localparam int          SOFT_RST_NS   = 200;
    localparam int          SOFT_RST_CYC  = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [3:0]  ADDR_PAGE_SEL = 4'h7;
    localparam logic [3:0]  ADDR_COMPL    = 4'h8;
    localparam logic [3:0]  ADDR_ARB_CTRL = 4'h8;
    localparam logic [3:0]  ADDR_RSVD9    = 4'h9;
    localparam logic [3:0]  ADDR_OUI_HI   = 4'ha;
    localparam logic [3:0]  ADDR_OUI_MID  = 4'hb;
    localparam logic [3:0]  ADDR_OUI_LO   = 4'hc;
    localparam logic [3:0]  ADDR_PART_HI  = 4'hd;
    localparam logic [3:0]  ADDR_PART_MID = 4'he;
    localparam logic [3:0]  ADDR_SOFT_RST = 4'he;
    localparam logic [3:0]  ADDR_PART_LO  = 4'hf;

    localparam logic [2:0]  PAGE_PORT     = 3'h0;
    localparam logic [2:0]  PAGE_ID       = 3'h1;
    localparam logic [2:0]  PAGE_VEND     = 3'h7;

    localparam logic [7:0]  COMPLIANCE_VAL = 8'h01;

    localparam logic [1:0]  RATE_S100     = 2'h0;
    localparam logic [1:0]  RATE_S200     = 2'h1;
    localparam logic [1:0]  RATE_S400     = 2'h2;
    localparam logic [1:0]  RATE_ILLEGAL  = 2'h3;

    // bit position 0 of a byte location is data index 7
    localparam int          PAGE_HI       = 7;
    localparam int          PAGE_LO       = 5;
    localparam int          PORT_HI       = 3;
    localparam int          PORT_LO       = 0;
    localparam int          HOLD_IDX      = 7;
    localparam int          LSPD_HI       = 2;
    localparam int          LSPD_LO       = 1;
    localparam int          SOFT_RST_IDX  = 7;

    localparam logic [2:0]  PAGE_RST      = 3'h0;
    localparam logic [3:0]  PORT_RST      = 4'h0;
    localparam logic        HOLD_RST      = 1'b0;
    localparam logic [1:0]  LSPD_RST      = 2'h2;

    localparam logic [15:0] ACK_BITS      = 16'h0008;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic        done;
        logic [15:0] bits;
    } pkt_evt_t;

    typedef struct packed {
        logic [2:0] page;
        logic [3:0] port_sel;
        logic       hold_flag;
        logic [1:0] link_speed;
        logic [7:0] rdata;
        logic [1:0] pend;
        logic       soft_rst_req;
        logic [1:0] id_rate;
        logic [1:0] peer_rate;
    } core_state_t;

    localparam core_state_t CORE_RST = '{
        page: PAGE_RST, port_sel: PORT_RST, hold_flag: HOLD_RST,
        link_speed: LSPD_RST, rdata: 8'h00, pend: 2'h0, soft_rst_req: 1'b0,
        id_rate: LSPD_RST, peer_rate: RATE_S400
    };

    typedef enum logic [0:0] {
        STR_IDLE = 1'b0,
        STR_HOLD = 1'b1
    } stretch_state_t;

    typedef struct packed {
        stretch_state_t state;
        logic [7:0]     cnt;
        logic           hard_rst_n;
    } stretch_t;

endpackage

// *** logic/soft_reset_stretch.sv ***
// stretches a one-cycle software reset request into a hard reset pulse
`timescale 1ns/1ps
module soft_reset_stretch #(
    parameter int HOLD_CYC = phy_pages_pkg::SOFT_RST_CYC
) (
    input  logic mclk,
    input  logic rst_n,
    input  logic trigger,
    output logic hard_rst_n_r
);
    import phy_pages_pkg::*;

    generate
        if (HOLD_CYC < 1 || HOLD_CYC > 255) begin : g_bad_hold
            $error("HOLD_CYC must lie in 1..255");
        end
    endgenerate

    localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYC - 1);
    localparam stretch_t   STR_RST   = '{state: STR_IDLE, cnt: 8'h00, hard_rst_n: 1'b1};

    stretch_t st_r;
    stretch_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            STR_IDLE: begin
                if (trigger) begin
                    st_nxt.state      = STR_HOLD;
                    st_nxt.cnt        = HOLD_LAST;
                    st_nxt.hard_rst_n = 1'b0;
                end
            end
            STR_HOLD: begin
                if (st_r.cnt == 8'h00) begin
                    st_nxt.state      = STR_IDLE;
                    st_nxt.hard_rst_n = 1'b1;
                end else begin
                    st_nxt.cnt = st_r.cnt - 8'h01;
                end
            end
            default: begin
                st_nxt = STR_RST;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= STR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hard_rst_n_r = st_r.hard_rst_n;

    a_soft_hold_low : assert property (@(posedge mclk) disable iff (!rst_n)
        trigger && st_r.state == STR_IDLE |=> !hard_rst_n_r [*4] ##1 hard_rst_n_r)
        else $error("software reset pulse has wrong length");

endmodule

// *** logic/phy_id_vendor_pages.sv ***
// identification page and vendor control page behind the phy register window
//
// Notes on behaviour
// - page value 1 maps the identification page
// - first paged byte reads compliance level 01h
// - 24-bit maker code, high byte at 1010b
// - 24-bit part code, high byte at 1101b
// - page value 7 maps the vendor control page
// - hold set with acceleration on: only long packets clear requests
// - hold clear: any non-ack packet clears requests
// - hold flag zero after hard reset only
// - two-bit link speed, code 11 illegal
// - link speed copied into self-id rate
// - peers always told S400
// - link speed S400 after hard reset only
// - software reset bit forces a hard reset
// - software reset bit always reads zero
`timescale 1ns/1ps
module phy_id_vendor_pages #(
    parameter logic [23:0] MAKER_OUI = 24'h5ac3e1, // arbitrary value
    parameter logic [23:0] PART_CODE = 24'h9b7d20, // arbitrary value
    parameter int          HOLD_CYC  = phy_pages_pkg::SOFT_RST_CYC
) (
    input  logic                    mclk,
    input  logic                    rst_n,
    input  phy_pages_pkg::reg_req_t reg_req,
    output logic [7:0]              reg_rdata,
    input  logic                    accel_on,
    input  logic [1:0]              req_set,
    input  phy_pages_pkg::pkt_evt_t pkt,
    output logic [1:0]              req_pend,
    output logic [1:0]              self_id_rate_field,
    output logic [1:0]              peer_rate,
    output logic                    hard_reset_n
);
    import phy_pages_pkg::*;

    generate
        if (HOLD_CYC < 1) begin : g_bad_hold
            $error("HOLD_CYC must be at least 1");
        end
    endgenerate

    core_state_t st_r;
    core_state_t st_nxt;
    logic        hard_rst_n_r;
    logic        core_rst_n;

    // hard reset from the pin or from the software trigger
    assign core_rst_n = rst_n & hard_rst_n_r;

    // true when a finished packet clears the pending requests
    function automatic logic pkt_clears(
        input logic        hold,
        input logic        accel,
        input logic [15:0] bits
    );
        logic clr;
        clr = 1'b0;
        if (hold && accel) begin
            clr = (bits > ACK_BITS);
        end else begin
            clr = (bits != ACK_BITS);
        end
        return clr;
    endfunction

    // byte presented for a register read at the given address
    function automatic logic [7:0] read_byte(
        input core_state_t s,
        input logic [3:0]  a
    );
        logic [7:0] b;
        b = 8'h00;
        if (a == ADDR_PAGE_SEL) begin
            b[PAGE_HI:PAGE_LO] = s.page;
            b[PORT_HI:PORT_LO] = s.port_sel;
        end else if (a[3]) begin
            case (s.page)
                PAGE_ID: begin
                    case (a)
                        ADDR_COMPL:    b = COMPLIANCE_VAL;
                        ADDR_OUI_HI:   b = MAKER_OUI[23:16];
                        ADDR_OUI_MID:  b = MAKER_OUI[15:8];
                        ADDR_OUI_LO:   b = MAKER_OUI[7:0];
                        ADDR_PART_HI:  b = PART_CODE[23:16];
                        ADDR_PART_MID: b = PART_CODE[15:8];
                        ADDR_PART_LO:  b = PART_CODE[7:0];
                        default:       b = 8'h00;
                    endcase
                end
                PAGE_VEND: begin
                    // software reset and test locations read zero
                    if (a == ADDR_ARB_CTRL) begin
                        b[HOLD_IDX]        = s.hold_flag;
                        b[LSPD_HI:LSPD_LO] = s.link_speed;
                    end
                end
                default: begin
                    b = 8'h00;
                end
            endcase
        end
        return b;
    endfunction

    always_comb begin
        st_nxt         = st_r;
        st_nxt.rdata   = 8'h00;
        st_nxt.soft_rst_req = 1'b0;

        if (reg_req.wr) begin
            if (reg_req.addr == ADDR_PAGE_SEL) begin
                st_nxt.page     = reg_req.wdata[PAGE_HI:PAGE_LO];
                st_nxt.port_sel = reg_req.wdata[PORT_HI:PORT_LO];
            end
            if (st_r.page == PAGE_VEND && reg_req.addr == ADDR_ARB_CTRL) begin
                st_nxt.hold_flag = reg_req.wdata[HOLD_IDX];
                // an illegal speed code is dropped and the old value kept
                if (reg_req.wdata[LSPD_HI:LSPD_LO] != RATE_ILLEGAL) begin
                    st_nxt.link_speed = reg_req.wdata[LSPD_HI:LSPD_LO];
                end
            end
            if (st_r.page == PAGE_VEND && reg_req.addr == ADDR_SOFT_RST) begin
                st_nxt.soft_rst_req = reg_req.wdata[SOFT_RST_IDX];
            end
        end

        if (reg_req.rd) begin
            st_nxt.rdata = read_byte(st_r, reg_req.addr);
        end

        // a new request wins over a clear in the same cycle
        for (int k = 0; k < 2; k++) begin
            if (req_set[k]) begin
                st_nxt.pend[k] = 1'b1;
            end else if (pkt.done && pkt_clears(st_r.hold_flag, accel_on, pkt.bits)) begin
                st_nxt.pend[k] = 1'b0;
            end
        end

        st_nxt.id_rate   = st_r.link_speed;
        st_nxt.peer_rate = RATE_S400;
    end

    // bus reset does not touch this state; only hard reset does
    always_ff @(posedge mclk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            st_r <= CORE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    soft_reset_stretch #(
        .HOLD_CYC (HOLD_CYC)
    ) u_stretch (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .trigger      (st_r.soft_rst_req),
        .hard_rst_n_r (hard_rst_n_r)
    );

    assign reg_rdata          = st_r.rdata;
    assign req_pend           = st_r.pend;
    assign self_id_rate_field = st_r.id_rate;
    assign peer_rate          = st_r.peer_rate;
    assign hard_reset_n       = hard_rst_n_r;

    default clocking cb @(posedge mclk);
    endclocking

    default disable iff (!core_rst_n);

    sequence s_read(logic [2:0] pg, logic [3:0] a);
        reg_req.rd && !reg_req.wr && st_r.page == pg && reg_req.addr == a;
    endsequence

    sequence s_ctrl_write;
        reg_req.wr && st_r.page == PAGE_VEND && reg_req.addr == ADDR_ARB_CTRL;
    endsequence

    sequence s_select(logic [2:0] pg);
        reg_req.wr && reg_req.addr == ADDR_PAGE_SEL && reg_req.wdata[PAGE_HI:PAGE_LO] == pg;
    endsequence

    a_id_compliance : assert property (s_read(PAGE_ID, ADDR_COMPL)
        |=> reg_rdata == COMPLIANCE_VAL)
        else $error("compliance byte wrong");

    a_id_page_map : assert property (s_select(PAGE_ID)
        ##1 (reg_req.rd && !reg_req.wr && reg_req.addr == ADDR_OUI_HI)
        |=> reg_rdata == MAKER_OUI[23:16])
        else $error("maker code high byte not seen after page select");

    a_part_high : assert property (s_read(PAGE_ID, ADDR_PART_HI)
        |=> reg_rdata == PART_CODE[23:16])
        else $error("part code high byte wrong");

    a_vend_page_map : assert property (s_select(PAGE_VEND)
        ##1 (reg_req.rd && !reg_req.wr && reg_req.addr == ADDR_ARB_CTRL)
        |=> reg_rdata[LSPD_HI:LSPD_LO] == $past(st_r.link_speed)
            && reg_rdata[HOLD_IDX] == $past(st_r.hold_flag))
        else $error("vendor control byte not seen after page select");

    a_hold_keeps_req : assert property (st_r.hold_flag && accel_on && pkt.done
        && pkt.bits <= ACK_BITS && req_pend[0] |=> req_pend[0])
        else $error("short packet cleared a held request");

    a_any_pkt_clears : assert property (!st_r.hold_flag && pkt.done
        && pkt.bits != ACK_BITS && !req_set[1] |=> !req_pend[1])
        else $error("non-ack packet left a request pending");

    a_reset_values : assert property ($rose(core_rst_n)
        |-> !st_r.hold_flag && st_r.link_speed == LSPD_RST)
        else $error("hold flag or link speed wrong after hard reset");

    a_speed_legal : assert property (st_r.link_speed != RATE_ILLEGAL)
        else $error("illegal link speed code stored");

    a_selfid_copy : assert property (##1 self_id_rate_field
        == $past(st_r.link_speed))
        else $error("self-id rate does not follow link speed");

    a_peer_s400 : assert property (##1 peer_rate == RATE_S400)
        else $error("peer rate is not S400");

    a_soft_reads_zero : assert property (s_read(PAGE_VEND, ADDR_SOFT_RST)
        |=> reg_rdata == 8'h00)
        else $error("software reset location read nonzero");

    a_reserved_zero : assert property (s_read(PAGE_ID, ADDR_RSVD9)
        |=> reg_rdata == 8'h00)
        else $error("reserved location read nonzero");

    a_soft_fires : assert property (s_select(PAGE_VEND)
        ##1 (reg_req.wr && reg_req.addr == ADDR_SOFT_RST && reg_req.wdata[SOFT_RST_IDX])
        |=> ##1 !hard_reset_n)
        else $error("software reset write did not reset");

    a_oui_mid : assert property (s_read(PAGE_ID, ADDR_OUI_MID)
        |=> reg_rdata == MAKER_OUI[15:8])
        else $error("maker code middle byte wrong");

    a_oui_low : assert property (s_read(PAGE_ID, ADDR_OUI_LO)
        |=> reg_rdata == MAKER_OUI[7:0])
        else $error("maker code low byte wrong");

    a_part_mid : assert property (s_read(PAGE_ID, ADDR_PART_MID)
        |=> reg_rdata == PART_CODE[15:8])
        else $error("part code middle byte wrong");

    a_part_low : assert property (s_read(PAGE_ID, ADDR_PART_LO)
        |=> reg_rdata == PART_CODE[7:0])
        else $error("part code low byte wrong");

    a_page_back : assert property (reg_req.rd && reg_req.addr == ADDR_PAGE_SEL
        |=> reg_rdata == {$past(st_r.page), 1'b0, $past(st_r.port_sel)})
        else $error("page select readback wrong");

    a_page_write : assert property (reg_req.wr && reg_req.addr == ADDR_PAGE_SEL
        |=> st_r.page == $past(reg_req.wdata[PAGE_HI:PAGE_LO]))
        else $error("page select not stored");

    a_base_zero : assert property (reg_req.rd && reg_req.addr < ADDR_PAGE_SEL
        |=> reg_rdata == 8'h00)
        else $error("base location read nonzero");

    a_rdata_idle : assert property (!reg_req.rd |=> reg_rdata == 8'h00)
        else $error("read data without a read");

    a_port_page_zero : assert property (reg_req.rd && st_r.page == PAGE_PORT
        && reg_req.addr[3] |=> reg_rdata == 8'h00)
        else $error("port page location read nonzero");

    a_vend_test_zero : assert property (s_read(PAGE_VEND, ADDR_RSVD9)
        |=> reg_rdata == 8'h00)
        else $error("test location read nonzero");

    a_vend_oui_zero : assert property (s_read(PAGE_VEND, ADDR_OUI_HI)
        |=> reg_rdata == 8'h00)
        else $error("maker code seen on vendor page");

    a_vend_part_zero : assert property (s_read(PAGE_VEND, ADDR_PART_HI)
        |=> reg_rdata == 8'h00)
        else $error("part code seen on vendor page");

    a_ctrl_spare_zero : assert property (s_read(PAGE_VEND, ADDR_ARB_CTRL)
        |=> reg_rdata[6:3] == 4'h0 && !reg_rdata[0])
        else $error("spare control bits read nonzero");

    a_hold_write : assert property (s_ctrl_write
        |=> st_r.hold_flag == $past(reg_req.wdata[HOLD_IDX]))
        else $error("hold flag not stored");

    a_speed_write : assert property (s_ctrl_write
        ##0 reg_req.wdata[LSPD_HI:LSPD_LO] != RATE_ILLEGAL
        |=> st_r.link_speed == $past(reg_req.wdata[LSPD_HI:LSPD_LO]))
        else $error("link speed not stored");

    a_illegal_kept : assert property (s_ctrl_write
        ##0 reg_req.wdata[LSPD_HI:LSPD_LO] == RATE_ILLEGAL |=> $stable(st_r.link_speed))
        else $error("illegal link speed code stored");

    a_rate_follows : assert property (s_ctrl_write
        ##0 reg_req.wdata[LSPD_HI:LSPD_LO] != RATE_ILLEGAL
        |=> ##1 self_id_rate_field == $past(reg_req.wdata[LSPD_HI:LSPD_LO], 2))
        else $error("self-id rate missed a link speed write");

    a_speed_kept : assert property (!(reg_req.wr && reg_req.addr == ADDR_ARB_CTRL)
        |=> $stable(st_r.link_speed))
        else $error("link speed changed without a write");

    a_hold_kept : assert property (!(reg_req.wr && reg_req.addr == ADDR_ARB_CTRL)
        |=> $stable(st_r.hold_flag))
        else $error("hold flag changed without a write");

    a_id_write_ignored : assert property (reg_req.wr && st_r.page == PAGE_ID
        |=> $stable(st_r.hold_flag) && $stable(st_r.link_speed))
        else $error("write on identification page changed state");

    a_fair_set : assert property (req_set[0] |=> req_pend[0])
        else $error("fair request not pending");

    a_prio_set : assert property (req_set[1] |=> req_pend[1])
        else $error("priority request not pending");

    a_ack_keeps : assert property (pkt.done && pkt.bits == ACK_BITS && req_pend[1]
        |=> req_pend[1])
        else $error("ack packet cleared a request");

    a_long_clears : assert property (st_r.hold_flag && accel_on && pkt.done
        && pkt.bits > ACK_BITS && !req_set[0] |=> !req_pend[0])
        else $error("long packet left a request pending");

    a_pend_holds : assert property (!pkt.done && req_pend[0] |=> req_pend[0])
        else $error("request cleared without a packet");

    a_soft_bit_clear : assert property (reg_req.wr && st_r.page == PAGE_VEND
        && reg_req.addr == ADDR_SOFT_RST && !reg_req.wdata[SOFT_RST_IDX] |=> !st_r.soft_rst_req)
        else $error("software reset raised by a zero bit");

    a_peer_always : assert property (peer_rate == RATE_S400)
        else $error("peer rate left S400");

endmodule

// *** tb/llc_model.sv ***
// link-layer controller model that issues phy register reads and writes
`timescale 1ns/1ps
module llc_model (
    input  wire logic               mclk,
    output phy_pages_pkg::reg_req_t reg_req
);
    import phy_pages_pkg::*;

    initial reg_req = '0;

    // released lines toggle so a stale value never passes for data
    task automatic idle();
        reg_req <= '{addr: ~reg_req.addr, wdata: ~reg_req.wdata, wr: 1'b0, rd: 1'b0};
        @(posedge mclk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
    endtask

    task automatic rd(input logic [3:0] a);
        reg_req <= '{addr: a, wdata: ~reg_req.wdata, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
    endtask

    task automatic sel_page(input logic [2:0] p, input logic [3:0] port);
        wr(ADDR_PAGE_SEL, {p, 1'b0, port});
    endtask

    // callers pass code 11 only where the refusal itself is under test
    task automatic set_ctrl(input logic h, input logic [1:0] s);
        wr(ADDR_ARB_CTRL, {h, 4'h0, s, 1'b0});
    endtask
endmodule

// *** tb/phy_id_vendor_pages_tb_top.sv ***
// self-checking bench for the phy identification and vendor control pages
`timescale 1ns/1ps
module phy_id_vendor_pages_tb_top;
    import phy_pages_pkg::*;
    localparam int          RST_HOLD_CYC = 4;
    localparam logic [23:0] OUI     = 24'h3c961e; // arbitrary value
    localparam logic [23:0] PCODE   = 24'h71a4d8; // arbitrary value
    localparam logic [18:0] PC[9]   = '{19'h10000, 19'h20008, 19'h30003, 19'h60000,
                                        19'h60008, 19'h60005, 19'h70009, 19'h50000, 19'h40008};

    logic       mclk;
    logic       rst_n;
    reg_req_t   reg_req;
    logic [7:0] reg_rdata;
    logic       accel_on;
    logic [1:0] req_set;
    pkt_evt_t   pkt;
    logic [1:0] req_pend;
    logic [1:0] self_id_rate_field;
    logic [1:0] peer_rate;
    logic       hard_reset_n;
    logic       rd_seen;
    logic [7:0] exp_q[$];
    int         failures = 0;
    int         compares = 0;

    phy_id_vendor_pages #(.MAKER_OUI(OUI), .PART_CODE(PCODE), .HOLD_CYC(RST_HOLD_CYC)) dut (
        .mclk(mclk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .accel_on(accel_on), .req_set(req_set), .pkt(pkt), .req_pend(req_pend),
        .self_id_rate_field(self_id_rate_field), .peer_rate(peer_rate),
        .hard_reset_n(hard_reset_n));

    llc_model llc (.mclk(mclk), .reg_req(reg_req));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // read data stand only in the cycle after the read strobe
    always @(posedge mclk) begin
        if (rd_seen) begin
            if (exp_q.size() > 0)
                check(reg_rdata, exp_q.pop_front(), "reg_rdata");
            else
                check(8'h00, 8'h01, "unexpected read");
        end
        rd_seen <= reg_req.rd;
    end

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        llc.rd(a);
    endtask

    task automatic pkt_rx(input logic [15:0] b);
        pkt <= '{done: 1'b1, bits: b};
        @(posedge mclk);
        pkt <= '{done: 1'b0, bits: ~b};
        @(posedge mclk);
    endtask

    initial begin
        logic       h;
        logic [1:0] s;
        logic [1:0] last_s;
        int         lowcnt;
        rst_n = 1'b0;
        accel_on = 1'b0;
        req_set = 2'h0;
        pkt = '0;
        rd_seen = 1'b0;
        void'($urandom(52));
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        llc.sel_page(PAGE_VEND, 4'h0);
        rd_chk(ADDR_ARB_CTRL, 8'h04);
        llc.idle();
        check({6'h0, self_id_rate_field}, 8'h02, "self_id_rate_field");
        // identification page, writes there are refused
        llc.sel_page(PAGE_ID, 4'h5);
        rd_chk(ADDR_PAGE_SEL, 8'h25);
        rd_chk(4'h0, 8'h00);
        llc.wr(ADDR_COMPL, 8'hff);
        rd_chk(ADDR_COMPL, COMPLIANCE_VAL);
        rd_chk(ADDR_RSVD9, 8'h00);
        for (int i = 0; i < 3; i++) begin
            rd_chk(4'(ADDR_OUI_HI + i), OUI[23 - 8 * i -: 8]);
            rd_chk(4'(ADDR_PART_HI + i), PCODE[23 - 8 * i -: 8]);
        end
        // link speed codes with random hold flag
        llc.sel_page(PAGE_VEND, 4'h0);
        for (int i = 0; i < 6; i++) begin
            h = 1'($urandom_range(1, 0));
            s = 2'(i % 3);
            llc.set_ctrl(h, s);
            rd_chk(ADDR_ARB_CTRL, {h, 4'h0, s, 1'b0});
            llc.idle();
            check({6'h0, self_id_rate_field}, {6'h0, s}, "self_id_rate_field");
            check({6'h0, peer_rate}, {6'h0, RATE_S400}, "peer_rate");
        end
        last_s = s;
        llc.set_ctrl(1'b1, RATE_ILLEGAL);
        rd_chk(ADDR_ARB_CTRL, {1'b1, 4'h0, last_s, 1'b0});
        llc.wr(ADDR_SOFT_RST, 8'h7f);
        rd_chk(ADDR_SOFT_RST, 8'h00);
        rd_chk(ADDR_OUI_HI, 8'h00);
        llc.idle();
        // pending request clearing per packet length, hold flag and acceleration
        for (int i = 0; i < 10; i++) begin
            logic [18:0] c;
            c = (i < 9) ? PC[i] : {3'b111, 16'($urandom_range(65535, 9))};
            llc.set_ctrl(c[18], RATE_S400);
            llc.idle();
            accel_on <= c[17];
            req_set <= 2'h3;
            @(posedge mclk);
            req_set <= 2'h0;
            @(posedge mclk);
            check({6'h0, req_pend}, 8'h03, "req_pend set");
            pkt_rx(c[15:0]);
            check({6'h0, req_pend}, c[16] ? 8'h00 : 8'h03, "req_pend");
        end
        // software hard reset
        llc.set_ctrl(1'b1, RATE_S100);
        llc.wr(ADDR_SOFT_RST, 8'h80);
        llc.idle();
        lowcnt = 0;
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (hard_reset_n === 1'b0)
                lowcnt++;
        end
        check(8'(lowcnt), 8'(RST_HOLD_CYC), "hard reset cycles");
        check({7'h0, hard_reset_n}, 8'h01, "hard_reset_n");
        check({6'h0, req_pend}, 8'h00, "req_pend after reset");
        rd_chk(ADDR_PAGE_SEL, 8'h00);
        llc.sel_page(PAGE_VEND, 4'h0);
        rd_chk(ADDR_ARB_CTRL, 8'h04);
        rd_chk(ADDR_SOFT_RST, 8'h00);
        llc.idle();
        check({6'h0, self_id_rate_field}, 8'h02, "self_id_rate_field");
        @(posedge mclk);
        check(8'(exp_q.size()), 8'h00, "reads left");
        end_of_test();
    end
endmodule
